/* File: hw/sso_pkg.sv */
// Constants shared by the receive section event-latch block and its per-channel slice.
package sso_pkg;

  // ----------------------------------------------------------------
  // Channel pages and sizes
  // ----------------------------------------------------------------
  localparam int NUM_CHAN = 3;  // Number of channel pages.
  localparam int TRACE_DEPTH = 64;  // Bytes in each trace message buffer.
  localparam logic [3:0] FIRST_PAGE = 4'h5;  // Page nibble of the first channel.
  localparam logic [3:0] LAST_PAGE = 4'h7;  // Page nibble of the last channel.

  // ----------------------------------------------------------------
  // Offsets inside a channel page
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_STATUS_B1 = 12'h106;  // Section status byte 1.
  localparam logic [11:0] OFF_STATUS_B0 = 12'h107;  // Section status byte 0.
  localparam logic [11:0] OFF_EVENT_B1 = 12'h10A;  // Event latch byte 1.
  localparam logic [11:0] OFF_TRACE_FIRST = 12'h300;  // First trace buffer byte.
  localparam logic [11:0] OFF_TRACE_LAST = 12'h33F;  // Last trace buffer byte.

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_NEW_S1 = 7;  // New S1 byte accepted.
  localparam int BIT_S1_UNST_CHG = 6;  // S1-unstable defect changed.
  localparam int BIT_TRACE_UNST_CHG = 5;  // Trace-unstable defect changed.
  localparam int BIT_NEW_TRACE = 4;  // New trace message accepted.
  localparam int BIT_TIM_CHG = 3;  // MS-TIM defect changed.
  localparam int BIT_UNUSED = 2;  // Unused, reads zero.
  localparam int BIT_K12_UNST_CHG = 1;  // K1/K2-unstable defect changed.
  localparam int BIT_NEW_K12 = 0;  // New K1/K2 pair accepted.
  localparam int STAT_B1_TIM_BIT = 2;  // MS-TIM level within status byte 1.
  localparam int STAT_B0_S1_UNST_BIT = 6;  // S1-unstable level within status byte 0.
  localparam int STAT_B0_K12_UNST_BIT = 5;  // K1/K2-unstable level within status byte 0.

  // ----------------------------------------------------------------
  // Reset value and unmapped-read value
  // ----------------------------------------------------------------
  localparam logic [7:0] EVENT_RESET = 8'h00;  // Event latch byte after reset.
  localparam logic [7:0] ZERO_BYTE = 8'h00;  // Value of unmapped reads.

endpackage

/* File: hw/sso_chan_events.sv */
// Per-channel event latch byte with clear-on-read and defect change detection.
`timescale 1ns/1ns
module sso_chan_events
  import sso_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic new_s1,
  input wire logic s1_unstable,
  input wire logic trace_unstable,
  input wire logic new_trace,
  input wire logic tim_defect,
  input wire logic k12_unstable,
  input wire logic new_k12,
  input wire logic clear_on_read,
  output logic [7:0] event_byte,
  output logic tim_level,
  output logic s1_unstable_level,
  output logic k12_unstable_level
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // The latched byte and the last seen level of each defect.
  typedef struct packed {
    logic [7:0] events;
    logic s1_unst;
    logic trace_unst;
    logic tim;
    logic k12_unst;
  } sso_chan_state_type;

  sso_chan_state_type state;  // Registered state.
  sso_chan_state_type next_state;  // Value for the next edge.
  logic [7:0] set_bits;  // Events seen this cycle.

  // Compute the events of this cycle and the next latched byte.
  always_comb begin
    set_bits = EVENT_RESET;
    set_bits[BIT_NEW_S1] = new_s1;
    set_bits[BIT_S1_UNST_CHG] = s1_unstable ^ state.s1_unst;
    set_bits[BIT_TRACE_UNST_CHG] = trace_unstable ^ state.trace_unst;
    set_bits[BIT_NEW_TRACE] = new_trace;
    set_bits[BIT_TIM_CHG] = tim_defect ^ state.tim;
    set_bits[BIT_K12_UNST_CHG] = k12_unstable ^ state.k12_unst;
    set_bits[BIT_NEW_K12] = new_k12;
    next_state = state;
    // A read clears the byte, but an event of the same cycle is kept.
    if (clear_on_read) begin
      next_state.events = set_bits;
    end else begin
      next_state.events = state.events | set_bits;
    end
    next_state.events[BIT_UNUSED] = 1'b0;
    next_state.s1_unst = s1_unstable;
    next_state.trace_unst = trace_unstable;
    next_state.tim = tim_defect;
    next_state.k12_unst = k12_unstable;
  end

  // Register the state; reset clears every bit.
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign event_byte = state.events;
  assign tim_level = state.tim;
  assign s1_unstable_level = state.s1_unst;
  assign k12_unstable_level = state.k12_unst;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_new_s1_sets;
    new_s1 |=> event_byte[BIT_NEW_S1];
  endproperty
  a_new_s1_sets: assert property (p_new_s1_sets) else $error("new S1 not latched");

  property p_s1_change_sets;
    $changed(s1_unstable) |-> ##1 event_byte[BIT_S1_UNST_CHG];
  endproperty
  a_s1_change_sets: assert property (p_s1_change_sets) else $error("S1 change lost");

  property p_trace_change_sets;
    (trace_unstable != $past(trace_unstable)) |=> event_byte[BIT_TRACE_UNST_CHG];
  endproperty
  a_trace_change_sets: assert property (p_trace_change_sets)
    else $error("trace change lost");

  property p_new_trace_sets;
    new_trace |=> event_byte[BIT_NEW_TRACE];
  endproperty
  a_new_trace_sets: assert property (p_new_trace_sets) else $error("new trace lost");

  property p_tim_change_sets;
    ($rose(tim_defect) or $fell(tim_defect))
      |=> event_byte[BIT_TIM_CHG] && tim_level == $past(tim_defect);
  endproperty
  a_tim_change_sets: assert property (p_tim_change_sets) else $error("TIM change lost");

  property p_k12_change_sets;
    $changed(k12_unstable) |=> event_byte[BIT_K12_UNST_CHG];
  endproperty
  a_k12_change_sets: assert property (p_k12_change_sets) else $error("K1K2 change lost");

  property p_new_k12_sets;
    new_k12 |=> event_byte[BIT_NEW_K12];
  endproperty
  a_new_k12_sets: assert property (p_new_k12_sets) else $error("new K1K2 lost");

  property p_bit_holds;
    event_byte[BIT_NEW_S1] && !clear_on_read |=> event_byte[BIT_NEW_S1];
  endproperty
  a_bit_holds: assert property (p_bit_holds) else $error("latched bit dropped");

  property p_read_clears;
    clear_on_read && !new_s1 && !new_trace && !new_k12 && $stable(tim_defect)
      && $stable(s1_unstable) && $stable(trace_unstable) && $stable(k12_unstable)
      ##1 1'b1 |-> event_byte == EVENT_RESET;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear");

  property p_set_beats_clear;
    clear_on_read && new_trace |=> event_byte[BIT_NEW_TRACE];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("event lost on read");

  property p_unused_zero;
    event_byte[BIT_UNUSED] == 1'b0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

endmodule

/* File: hw/sso_event_regs.sv */
// Receive section event latch byte, defect levels and trace buffer for all channels.
`timescale 1ns/1ns
module sso_event_regs
  import sso_pkg::*;
#(
  parameter int CHANNELS = NUM_CHAN,  // Channel pages in use.
  parameter int TRACE_BYTES = TRACE_DEPTH,  // Trace buffer bytes per channel.
  localparam int CHAN_W = $clog2(CHANNELS),  // Width of a channel number.
  localparam int TRACE_AW = $clog2(TRACE_BYTES)  // Width of a trace byte index.
)
(
  input wire logic clk,
  input wire logic reset,
  // Microprocessor read port.
  input wire logic rd_strobe,
  input wire logic [15:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_ack,
  // Event pulses and defect levels from the receive overhead detectors.
  input wire logic [CHANNELS-1:0] new_s1,
  input wire logic [CHANNELS-1:0] s1_unstable,
  input wire logic [CHANNELS-1:0] trace_unstable,
  input wire logic [CHANNELS-1:0] new_trace,
  input wire logic [CHANNELS-1:0] tim_defect,
  input wire logic [CHANNELS-1:0] k12_unstable,
  input wire logic [CHANNELS-1:0] new_k12,
  // Trace message write port from the trace detector.
  input wire logic trace_wr,
  input wire logic [CHAN_W-1:0] trace_wr_chan,
  input wire logic [TRACE_AW-1:0] trace_wr_index,
  input wire logic [7:0] trace_wr_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Read answer and the trace buffers of every channel, one flat array.
  typedef struct packed {
    logic [7:0] rd_data;
    logic rd_ack;
    logic [CHANNELS*TRACE_BYTES-1:0][7:0] trace;
  } sso_regs_state_type;

  sso_regs_state_type state;  // Registered state.
  sso_regs_state_type next_state;  // Value for the next edge.

  // Outputs of the channel slices and their clear-on-read inputs.
  logic [CHANNELS-1:0][7:0] event_byte;  // Latched event bytes.
  logic [CHANNELS-1:0] tim_level;  // MS-TIM defect levels.
  logic [CHANNELS-1:0] s1_unst_level;  // S1-unstable defect levels.
  logic [CHANNELS-1:0] k12_unst_level;  // K1/K2-unstable defect levels.
  logic [CHANNELS-1:0] clear_on_read;  // Read of a channel's event byte.

  // Address decode.
  logic [3:0] rd_page;  // Channel page nibble.
  logic [11:0] rd_offset;  // Offset inside the page.
  logic page_hit;  // Page belongs to a channel.
  logic [CHAN_W-1:0] rd_chan;  // Channel of the page.

  assign rd_page = rd_addr[15:12];
  assign rd_offset = rd_addr[11:0];
  assign page_hit = (rd_page >= FIRST_PAGE) && (rd_page <= LAST_PAGE)
    && (rd_page - FIRST_PAGE < 4'(CHANNELS));
  assign rd_chan = CHAN_W'(rd_page - FIRST_PAGE);

  // ----------------------------------------------------------------
  // Channel slices
  // ----------------------------------------------------------------
  // One event latch per channel; each clears only on a read of its own page.
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    assign clear_on_read[ch] = rd_strobe && (rd_page == FIRST_PAGE + 4'(ch))
      && (rd_offset == OFF_EVENT_B1);

    sso_chan_events u_events (
      .clk(clk),
      .reset(reset),
      .new_s1(new_s1[ch]),
      .s1_unstable(s1_unstable[ch]),
      .trace_unstable(trace_unstable[ch]),
      .new_trace(new_trace[ch]),
      .tim_defect(tim_defect[ch]),
      .k12_unstable(k12_unstable[ch]),
      .new_k12(new_k12[ch]),
      .clear_on_read(clear_on_read[ch]),
      .event_byte(event_byte[ch]),
      .tim_level(tim_level[ch]),
      .s1_unstable_level(s1_unst_level[ch]),
      .k12_unstable_level(k12_unst_level[ch])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Store trace bytes and select the read answer.
  always_comb begin
    next_state = state;
    next_state.rd_ack = rd_strobe;
    // Writes to a channel beyond the last one are dropped.
    if (trace_wr && (int'(trace_wr_chan) < CHANNELS)) begin
      next_state.trace[{trace_wr_chan, trace_wr_index}] = trace_wr_data;
    end
    // The answer holds the byte as it stood before any clear of this read.
    if (rd_strobe) begin
      next_state.rd_data = ZERO_BYTE;
      if (page_hit) begin
        if (rd_offset == OFF_STATUS_B1) begin
          next_state.rd_data[STAT_B1_TIM_BIT] = tim_level[rd_chan];
        end else if (rd_offset == OFF_STATUS_B0) begin
          next_state.rd_data[STAT_B0_S1_UNST_BIT] = s1_unst_level[rd_chan];
          next_state.rd_data[STAT_B0_K12_UNST_BIT] = k12_unst_level[rd_chan];
        end else if (rd_offset == OFF_EVENT_B1) begin
          next_state.rd_data = event_byte[rd_chan];
        end else if ((rd_offset >= OFF_TRACE_FIRST) && (rd_offset <= OFF_TRACE_LAST)) begin
          next_state.rd_data = state.trace[{rd_chan, rd_offset[TRACE_AW-1:0]}];
        end
      end
    end
  end

  // Register the state; the trace buffers clear along with the rest.
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rd_data = state.rd_data;
  assign rd_ack = state.rd_ack;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_ack_follows_read;
    rd_strobe |=> rd_ack ##0 (rd_ack && $past(rd_strobe));
  endproperty
  a_ack_follows_read: assert property (p_ack_follows_read) else $error("read not acked");

  property p_event_read_value;
    rd_strobe && page_hit && rd_offset == OFF_EVENT_B1
      |=> rd_data == $past(event_byte[rd_chan]);
  endproperty
  a_event_read_value: assert property (p_event_read_value) else $error("bad event read");

  property p_tim_read_value;
    rd_strobe && page_hit && rd_offset == OFF_STATUS_B1
      |=> rd_data[STAT_B1_TIM_BIT] == $past(tim_level[rd_chan]);
  endproperty
  a_tim_read_value: assert property (p_tim_read_value) else $error("bad TIM level read");

  property p_s1_read_value;
    rd_strobe && page_hit && rd_offset == OFF_STATUS_B0
      |=> rd_data[STAT_B0_S1_UNST_BIT] == $past(s1_unst_level[rd_chan]);
  endproperty
  a_s1_read_value: assert property (p_s1_read_value) else $error("bad S1 level read");

  property p_trace_roundtrip;
    trace_wr && !rd_strobe ##1 rd_strobe && page_hit && rd_chan == $past(trace_wr_chan)
      && rd_offset == OFF_TRACE_FIRST + 12'($past(trace_wr_index)) && !trace_wr
      |=> rd_data == $past(trace_wr_data, 2);
  endproperty
  a_trace_roundtrip: assert property (p_trace_roundtrip) else $error("trace byte lost");

  property p_unmapped_zero;
    rd_strobe && !page_hit |=> rd_data == ZERO_BYTE;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

endmodule

/* File: dv/sso_detector_model.sv */
// Behavioural model of the receive overhead detectors that feed the event latch block.
`timescale 1ns/1ns
module sso_detector_model
  import sso_pkg::*;
(
  input wire logic clk,
  output logic [2:0] new_s1,
  output logic [2:0] s1_unstable,
  output logic [2:0] trace_unstable,
  output logic [2:0] new_trace,
  output logic [2:0] tim_defect,
  output logic [2:0] k12_unstable,
  output logic [2:0] new_k12,
  output logic trace_wr,
  output logic [1:0] trace_wr_chan,
  output logic [5:0] trace_wr_index,
  output logic [7:0] trace_wr_data
);
  // ----------------------------------------------------------------
  // Event lines
  // ----------------------------------------------------------------
  logic [7:0][2:0] ev;  // One row of channel lines for each event bit position.

  // Every line starts quiet so that no event is seen at reset release.
  initial begin
    ev = '0;
    trace_wr = 1'b0;
    trace_wr_chan = 2'h0;
    trace_wr_index = 6'h00;
    trace_wr_data = 8'h00;
  end

  assign new_s1 = ev[BIT_NEW_S1];
  assign s1_unstable = ev[BIT_S1_UNST_CHG];
  assign trace_unstable = ev[BIT_TRACE_UNST_CHG];
  assign new_trace = ev[BIT_NEW_TRACE];
  assign tim_defect = ev[BIT_TIM_CHG];
  assign k12_unstable = ev[BIT_K12_UNST_CHG];
  assign new_k12 = ev[BIT_NEW_K12];

  // Pulses an acceptance line for one cycle, or toggles a defect level for good.
  task automatic fire(input int k, input int c);
    @(posedge clk);
    ev[k][c] <= ~ev[k][c];
    if (k == BIT_NEW_S1 || k == BIT_NEW_TRACE || k == BIT_NEW_K12) begin
      @(posedge clk);
      ev[k][c] <= 1'b0;
    end
  endtask

  // Writes one trace byte; the released index and data lines show the inverse so stale values never match.
  task automatic write_trace(input logic [1:0] c, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk);
    trace_wr <= 1'b1;
    trace_wr_chan <= c;
    trace_wr_index <= i;
    trace_wr_data <= d;
    @(posedge clk);
    trace_wr <= 1'b0;
    trace_wr_index <= ~i;
    trace_wr_data <= ~d;
  endtask
endmodule

/* File: dv/test_sso_event_regs.sv */
// Self-checking bench for the receive section event latch block.
`timescale 1ns/1ns
module test_sso_event_regs
  import sso_pkg::*;
;
  logic clk;  // System clock, 50 MHz.
  logic reset;  // Synchronous reset, active high.
  logic rd_strobe;  // Read request pulse.
  logic [15:0] rd_addr;  // Read address.
  logic [7:0] rd_data;  // Read answer.
  logic rd_ack;  // Read answer marker.
  logic [2:0] new_s1, s1_unstable, trace_unstable, new_trace, tim_defect, k12_unstable, new_k12;
  logic trace_wr;  // Trace byte write pulse.
  logic [1:0] trace_wr_chan;  // Trace byte channel.
  logic [5:0] trace_wr_index;  // Trace byte index.
  logic [7:0] trace_wr_data;  // Trace byte value.
  int bad_count = 0;  // Mismatches seen.
  int n_checks = 0;  // Comparisons made.
  int cycles = 0;  // Clock cycles since start.

  sso_event_regs sso_event_regs_inst (.clk(clk), .reset(reset), .rd_strobe(rd_strobe),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_ack(rd_ack), .new_s1(new_s1),
    .s1_unstable(s1_unstable), .trace_unstable(trace_unstable), .new_trace(new_trace),
    .tim_defect(tim_defect), .k12_unstable(k12_unstable), .new_k12(new_k12),
    .trace_wr(trace_wr), .trace_wr_chan(trace_wr_chan), .trace_wr_index(trace_wr_index),
    .trace_wr_data(trace_wr_data));

  sso_detector_model sso_detector_model_inst (.clk(clk), .new_s1(new_s1),
    .s1_unstable(s1_unstable), .trace_unstable(trace_unstable), .new_trace(new_trace),
    .tim_defect(tim_defect), .k12_unstable(k12_unstable), .new_k12(new_k12),
    .trace_wr(trace_wr), .trace_wr_chan(trace_wr_chan), .trace_wr_index(trace_wr_index),
    .trace_wr_data(trace_wr_data));

  // ----------------------------------------------------------------
  // Clock, timeout and report
  // ----------------------------------------------------------------
  // The clock toggles every half period of 10 ns.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Prints the verdict and stops the run.
  task automatic test_done();
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Cuts a hang short well after the sequence should have ended.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // Compares one byte.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t byte %h expected %h at %h", $time, got, exp, rd_addr);
    end
  endtask

  // Compares one flag.
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // One-cycle read strobe; the answer is looked at once the taking edge has settled.
  task automatic expect_rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_strobe <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    chk1(rd_ack, 1'b1);
    chk8(rd_data, exp);
  endtask

  // Builds an address from a channel number and an offset.
  function automatic logic [15:0] at(input int c, input logic [11:0] off);
    return {FIRST_PAGE + 4'(c), off};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    rd_strobe = 1'b0;
    rd_addr = 16'h0000;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int c = 0; c < 3; c++) begin
      expect_rd(at(c, OFF_EVENT_B1), EVENT_RESET);
      expect_rd(at(c, OFF_STATUS_B1), ZERO_BYTE);
      expect_rd(at(c, OFF_STATUS_B0), ZERO_BYTE);
    end
    // Each event alone, declared in pass 0 and cleared in pass 1, on every channel.
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 3; c++) begin
        for (int i = 0; i < 8; i++) begin
          // The unused bit has no event line behind it.
          if (i == BIT_UNUSED) begin
            continue;
          end
          sso_detector_model_inst.fire(i, c);
          repeat (2) @(posedge clk);
          expect_rd(at(c, OFF_EVENT_B1), 8'h01 << i);
          expect_rd(at(c, OFF_EVENT_B1), ZERO_BYTE);
          expect_rd(at((c + 1) % 3, OFF_EVENT_B1), ZERO_BYTE);
        end
        expect_rd(at(c, OFF_STATUS_B1), (p == 0) ? 8'h04 : 8'h00);
        expect_rd(at(c, OFF_STATUS_B0), (p == 0) ? 8'h60 : 8'h00);
      end
    end
    // Events gather in the byte until read; the unused bit stays zero.
    for (int i = 0; i < 8; i++) begin
      if (i != BIT_UNUSED) begin
        sso_detector_model_inst.fire(i, 1);
      end
    end
    repeat (2) @(posedge clk);
    expect_rd(at(1, OFF_EVENT_B1), 8'hFB);
    sso_detector_model_inst.fire(BIT_S1_UNST_CHG, 1);
    sso_detector_model_inst.fire(BIT_TRACE_UNST_CHG, 1);
    sso_detector_model_inst.fire(BIT_TIM_CHG, 1);
    sso_detector_model_inst.fire(BIT_K12_UNST_CHG, 1);
    repeat (2) @(posedge clk);
    expect_rd(at(1, OFF_EVENT_B1), 8'h6A);
    // Events in the very cycle of the clearing read must survive it.
    fork
      sso_detector_model_inst.fire(BIT_NEW_S1, 2);
      sso_detector_model_inst.fire(BIT_NEW_TRACE, 2);
      expect_rd(at(2, OFF_EVENT_B1), ZERO_BYTE);
    join
    expect_rd(at(2, OFF_EVENT_B1), 8'h90);
    // Trace buffer edges on two channels, then unmapped places.
    sso_detector_model_inst.write_trace(2'h0, 6'h00, 8'hA5);
    sso_detector_model_inst.write_trace(2'h2, 6'h3F, 8'h3C);
    // A read taken the cycle right after a write sees the new byte.
    fork
      sso_detector_model_inst.write_trace(2'h1, 6'h05, 8'h5A);
      begin
        @(posedge clk);
        expect_rd(at(1, OFF_TRACE_FIRST + 12'h005), 8'h5A);
      end
    join
    expect_rd(at(0, OFF_TRACE_FIRST), 8'hA5);
    expect_rd(at(2, OFF_TRACE_LAST), 8'h3C);
    expect_rd(at(2, OFF_TRACE_FIRST), ZERO_BYTE);
    expect_rd(16'h410A, ZERO_BYTE);
    expect_rd(16'h810A, ZERO_BYTE);
    expect_rd(at(0, 12'h340), ZERO_BYTE);
    // A reset in mid-run wipes a pending event.
    sso_detector_model_inst.fire(BIT_NEW_K12, 0);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    expect_rd(at(0, OFF_EVENT_B1), EVENT_RESET);
    test_done();
  end
endmodule
